/* File: core/occ_comparator.v */
// Notes on behaviour
// - each comparator runs its own sinc3 filter, oversampling ratio 64
// - no offset or gain correction is applied to fast results
// - needs only the current ADC enabled, no conversions started
// - filter starts on comparator enable, independent of main conversions
// - result above high or below low threshold is an exceedance
// - high 7fff disables high check, low 8000 disables low check
// - 5-bit count sets exceedances needed; zero means one suffices
// - exceed counter clears on in-range result or comparator disable
// - detailed flags active low; combined flag low on unmasked flag
// - combined flag clears by write one only when detailed flags clear
// - mask blocks combined flag only; detailed flag still records
// - pin direction out and source zero routes comparator to pin
// - comparator pin shows high or low fault, ignoring masks
// - pin waveform follows per-pin format and polarity bits
// - big overshoot caught within one period; marginal within four
// - same modulator as current ADC; decision from fast filter only
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "occ_defs.vh"

module occ_comparator #(
  parameter OSR = `OCC_OSR,
  parameter PWM_DIV = `OCC_PWM_DIV
) (
  // clock and reset
  input wire ref_clk_in,
  input wire rstn_in,
  // modulator bitstreams, one per current adc
  input wire [1:0] mod_bit_in,
  input wire mod_clk_en_in,
  // register port
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [15:0] reg_rdata_out,
  // pins and interrupt
  output wire [1:0] pin_out,
  output wire [1:0] pin_oen_n_out,
  output wire irq_out
);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  reg [3:0] ctrl_q;
  reg [4:0] cfg_q [0:1];
  reg [15:0] hth_q [0:1];
  reg [15:0] lth_q [0:1];
  reg [3:0] mask_q;
  reg [7:0] pincfg_q;
  reg [3:0] status_n_q;
  reg combined_n_q;
  reg [2:0] irq_st_q;
  reg [2:0] irq_msk_q;
  reg [15:0] res_q [0:1];
  wire [3:0] fault_set;
  wire [1:0] res_valid;
  // condition still present: last compared result exceeded at full count
  wire [3:0] fault_hold;
  wire wr_status = reg_wr_in && reg_addr_in == `OCC_ADDR_STATUS;
  wire wr_fault = reg_wr_in && reg_addr_in == `OCC_ADDR_FAULT;
  // status bits after this cycle's host clears, before new sets
  // a write-one is ignored while the fault condition persists
  wire [3:0] status_cleared_n = status_n_q |
                                (wr_status ? (reg_wdata_in[3:0] & ~fault_hold) : 4'h0);
  // a write-one clears only where the condition is gone; set wins
  wire [3:0] status_d = status_cleared_n & ~fault_set;
  wire unmasked_fault = |(~status_d & ~mask_q);

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= 4'h0;
      cfg_q[0] <= 5'h00;
      cfg_q[1] <= 5'h00;
      hth_q[0] <= `OCC_HTH_RST;
      hth_q[1] <= `OCC_HTH_RST;
      lth_q[0] <= `OCC_LTH_RST;
      lth_q[1] <= `OCC_LTH_RST;
      mask_q <= 4'h0;
      pincfg_q <= `OCC_PINCFG_RST;
      status_n_q <= `COMPARATOR_STATUS_FLAGS_RST;
      combined_n_q <= 1'b1;
      irq_msk_q <= 3'h0;
    end else begin
      status_n_q <= status_d;
      // combined flag: sets from unmasked flag, clears only if all detailed clear
      if (unmasked_fault)
        combined_n_q <= 1'b0;
      else if (wr_fault && reg_wdata_in[0] && &status_d)
        combined_n_q <= 1'b1;
      if (reg_wr_in) begin
        // writes to config while enabled are accepted; host keeps ordering
        case (reg_addr_in)
          `OCC_ADDR_CTRL: ctrl_q <= reg_wdata_in[3:0];
          `OCC_ADDR_CFG_A: cfg_q[0] <= reg_wdata_in[4:0];
          `OCC_ADDR_HTH_A: hth_q[0] <= reg_wdata_in;
          `OCC_ADDR_LTH_A: lth_q[0] <= reg_wdata_in;
          `OCC_ADDR_CFG_B: cfg_q[1] <= reg_wdata_in[4:0];
          `OCC_ADDR_HTH_B: hth_q[1] <= reg_wdata_in;
          `OCC_ADDR_LTH_B: lth_q[1] <= reg_wdata_in;
          `OCC_ADDR_MASK: mask_q <= reg_wdata_in[3:0];
          `OCC_ADDR_PINCFG: pincfg_q <= reg_wdata_in[7:0];
          `OCC_ADDR_IRQ_MSK: irq_msk_q <= reg_wdata_in[2:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // interrupt: sticky events, write one to clear, set wins
  // ----------------------------------------
  wire [2:0] irq_ev = {|fault_set[3:2], |fault_set[1:0], |res_valid};
  wire [2:0] irq_clr = (reg_wr_in && reg_addr_in == `OCC_ADDR_IRQ_ST) ?
                       reg_wdata_in[2:0] : 3'h0;

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      irq_st_q <= 3'h0;
    else
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
  end

  assign irq_out = |(irq_st_q & irq_msk_q);

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `OCC_ADDR_CTRL: reg_rdata_out <= {12'h000, ctrl_q};
        `OCC_ADDR_CFG_A: reg_rdata_out <= {11'h000, cfg_q[0]};
        `OCC_ADDR_HTH_A: reg_rdata_out <= hth_q[0];
        `OCC_ADDR_LTH_A: reg_rdata_out <= lth_q[0];
        `OCC_ADDR_CFG_B: reg_rdata_out <= {11'h000, cfg_q[1]};
        `OCC_ADDR_HTH_B: reg_rdata_out <= hth_q[1];
        `OCC_ADDR_LTH_B: reg_rdata_out <= lth_q[1];
        `OCC_ADDR_STATUS: reg_rdata_out <= {12'h000, status_n_q};
        `OCC_ADDR_MASK: reg_rdata_out <= {12'h000, mask_q};
        `OCC_ADDR_FAULT: reg_rdata_out <= {15'h0000, combined_n_q};
        `OCC_ADDR_PINCFG: reg_rdata_out <= {8'h00, pincfg_q};
        `OCC_ADDR_IRQ_ST: reg_rdata_out <= {13'h0000, irq_st_q};
        `OCC_ADDR_IRQ_MSK: reg_rdata_out <= {13'h0000, irq_msk_q};
        `OCC_ADDR_RES_A: reg_rdata_out <= res_q[0];
        `OCC_ADDR_RES_B: reg_rdata_out <= res_q[1];
        default: reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

  // ----------------------------------------
  // per-comparator fast filter and threshold check
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      // 6 bits of growth per stage for osr 64; 20 bits keep +-2^18 apart
      reg [19:0] i1_q, i2_q, i3_q, d1_q, d2_q, d3_q;
      reg hi_act_q;
      reg lo_act_q;
      reg [5:0] dec_q;
      reg [1:0] warm_q;
      reg [4:0] cnt_q;
      reg val_q;
      // only the modulator, its own enable and the current adc enable drive it; no conversion state
      wire run = ctrl_q[g] && ctrl_q[2 + g];
      wire [19:0] x = mod_bit_in[g] ? 20'h00001 : 20'hfffff;
      wire [19:0] c1 = i3_q - d1_q;
      wire [19:0] c2 = c1 - d2_q;
      wire [19:0] c3 = c2 - d3_q;
      // full scale +-2^18 mapped to 16 bits; no calibration stage
      wire [15:0] res = (c3 == 20'h40000) ? 16'h7fff : c3[18:3];
      wire hi_ex = hth_q[g] != `OCC_HTH_OFF &&
                   $signed(res) > $signed(hth_q[g]);
      wire lo_ex = lth_q[g] != `OCC_LTH_OFF &&
                   $signed(res) < $signed(lth_q[g]);
      wire sample = run && mod_clk_en_in && dec_q == OSR - 1;
      wire good = sample && warm_q == 2'd2;
      wire reach = cnt_q >= cfg_q[g];

      always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          i1_q <= 20'h0;
          i2_q <= 20'h0;
          i3_q <= 20'h0;
          d1_q <= 20'h0;
          d2_q <= 20'h0;
          d3_q <= 20'h0;
          hi_act_q <= 1'b0;
          lo_act_q <= 1'b0;
          dec_q <= 6'h0;
          warm_q <= 2'h0;
          cnt_q <= 5'h0;
          val_q <= 1'b0;
          res_q[g] <= 16'h0000;
        end else if (!run) begin
          i1_q <= 20'h0;
          i2_q <= 20'h0;
          i3_q <= 20'h0;
          d1_q <= 20'h0;
          d2_q <= 20'h0;
          d3_q <= 20'h0;
          hi_act_q <= 1'b0;
          lo_act_q <= 1'b0;
          dec_q <= 6'h0;
          warm_q <= 2'h0;
          cnt_q <= 5'h0;
          val_q <= 1'b0;
        end else begin
          val_q <= good;
          if (mod_clk_en_in) begin
            i1_q <= i1_q + x;
            i2_q <= i2_q + i1_q;
            i3_q <= i3_q + i2_q;
            dec_q <= dec_q + 6'h1;
          end
          if (sample) begin
            d1_q <= i3_q;
            d2_q <= c1;
            d3_q <= c2;
            // first two results are unsettled and skipped
            if (warm_q != 2'd2)
              warm_q <= warm_q + 2'd1;
          end
          if (good) begin
            res_q[g] <= res;
            hi_act_q <= hi_ex && reach;
            lo_act_q <= lo_ex && reach;
            // counter saturates; in-range result restarts it
            if (hi_ex || lo_ex) begin
              if (!reach)
                cnt_q <= cnt_q + 5'h1;
            end else begin
              cnt_q <= 5'h0;
            end
          end
        end
      end

      // flag on the result that meets the count, one cycle per period
      assign fault_set[2 * g] = good && hi_ex && reach;
      assign fault_set[2 * g + 1] = good && lo_ex && reach;
      assign res_valid[g] = val_q;
      assign fault_hold[2 * g] = hi_act_q;
      assign fault_hold[2 * g + 1] = lo_act_q;
    end
  endgenerate

  // ----------------------------------------
  // fault pins
  // ----------------------------------------
  reg [4:0] pwm_q;
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      pwm_q <= 5'h0;
    else if (pwm_q == PWM_DIV - 1)
      pwm_q <= 5'h0;
    else
      pwm_q <= pwm_q + 5'h1;
  end
  // pwm: 50 percent square wave as the active waveform; inactive level is low
  wire pwm_wave = pwm_q < PWM_DIV / 2;

  wire [1:0] pin_fault = {~(status_n_q[3] & status_n_q[2]),
                          ~(status_n_q[1] & status_n_q[0])};
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : pin
      wire dir = pincfg_q[4 * p];
      wire src = pincfg_q[4 * p + 1];
      wire fmt = pincfg_q[4 * p + 2];
      wire pol = pincfg_q[4 * p + 3];
      // polarity 0: active low; format 1: active state toggles
      wire act_lvl = fmt ? pwm_wave : pol;
      wire inact_lvl = fmt ? 1'b0 : ~pol;
      reg lvl_q;
      always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
          lvl_q <= 1'b1;
        else
          lvl_q <= pin_fault[p] ? act_lvl : inact_lvl;
      end
      assign pin_out[p] = lvl_q;
      assign pin_oen_n_out[p] = ~(dir && !src);
    end
  endgenerate

endmodule

/* File: core/occ_defs.vh */
`ifndef OCC_DEFS_VH
`define OCC_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OCC_ADDR_CTRL     4'h0
`define OCC_ADDR_CFG_A    4'h1
`define OCC_ADDR_HTH_A    4'h2
`define OCC_ADDR_LTH_A    4'h3
`define OCC_ADDR_CFG_B    4'h4
`define OCC_ADDR_HTH_B    4'h5
`define OCC_ADDR_LTH_B    4'h6
`define OCC_ADDR_STATUS   4'h7
`define OCC_ADDR_MASK     4'h8
`define OCC_ADDR_FAULT    4'h9
`define OCC_ADDR_PINCFG   4'ha
`define OCC_ADDR_IRQ_ST   4'hb
`define OCC_ADDR_IRQ_MSK  4'hc
`define OCC_ADDR_RES_A    4'hd
`define OCC_ADDR_RES_B    4'he

// ----------------------------------------
// fields
// ----------------------------------------
`define OCC_CTRL_EN_A     0
`define OCC_CTRL_EN_B     1
`define OCC_CTRL_ADC_A    2
`define OCC_CTRL_ADC_B    3
`define OCC_ST_HT_A       0
`define OCC_ST_LT_A       1
`define OCC_ST_HT_B       2
`define OCC_ST_LT_B       3
`define OCC_PIN3_DIR      0
`define OCC_PIN3_SRC      1
`define OCC_PIN3_FMT      2
`define OCC_PIN_A_POL     3
`define OCC_PIN4_DIR      4
`define OCC_PIN4_SRC      5
`define OCC_PIN4_FMT      6
`define OCC_PIN_B_POL     7

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define OCC_HTH_RST       16'h7fff
`define OCC_LTH_RST       16'h8000
`define OCC_HTH_OFF       16'h7fff
`define OCC_LTH_OFF       16'h8000
`define COMPARATOR_STATUS_FLAGS_RST    4'hf
`define OCC_PINCFG_RST    8'h00
`define OCC_OSR           64
`define OCC_PWM_DIV       16

`endif

/* File: bench/occ_mod_model.sv */
`timescale 1ns/1ps
module occ_mod_model (
  // clock and reset
  input wire ref_clk_in,
  input wire rstn_in,
  // input density, 8'h80 is mid scale
  input wire [7:0] level_a_in,
  input wire [7:0] level_b_in,
  // bitstreams toward the comparators
  output reg [1:0] mod_bit_out,
  output reg mod_clk_en_out
);
  reg [7:0] acc_a_q;
  reg [7:0] acc_b_q;
  // first-order loop, free running: no conversion start is needed
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_a_q <= 8'h00;
      acc_b_q <= 8'h00;
      mod_bit_out <= 2'b00;
      mod_clk_en_out <= 1'b0;
    end else begin
      mod_clk_en_out <= !mod_clk_en_out;
      if (!mod_clk_en_out) begin
        {mod_bit_out[0], acc_a_q} <= acc_a_q + level_a_in;
        {mod_bit_out[1], acc_b_q} <= acc_b_q + level_b_in;
      end
    end
  end
endmodule

/* File: bench/occ_assertions.sv */
`timescale 1ns/1ps
`include "occ_defs.vh"
module occ_assertions #(
  parameter OSR = `OCC_OSR,
  parameter PWM_DIV = `OCC_PWM_DIV
) (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire [1:0] mod_bit_in,
  input wire mod_clk_en_in,
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [15:0] reg_rdata_out,
  input wire [1:0] pin_out,
  input wire [1:0] pin_oen_n_out,
  input wire irq_out
);
  reg [7:0] pcfg_q;
  reg [2:0] imsk_q;
  reg [15:0] hth_q;
  reg rd_st_q;
  wire a_low = rd_st_q && reg_rdata_out[1:0] != 2'b11 && !reg_wr_in && !pcfg_q[2];
  wire b_low = rd_st_q && reg_rdata_out[3:2] != 2'b11 && !reg_wr_in && !pcfg_q[6];
  // shadows of write-only-by-host registers
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pcfg_q <= `OCC_PINCFG_RST;
      imsk_q <= 3'h0;
      hth_q <= `OCC_HTH_RST;
      rd_st_q <= 1'b0;
    end else begin
      rd_st_q <= reg_rd_in && reg_addr_in == `OCC_ADDR_STATUS;
      if (reg_wr_in) begin
        case (reg_addr_in)
          `OCC_ADDR_PINCFG: pcfg_q <= reg_wdata_in[7:0];
          `OCC_ADDR_IRQ_MSK: imsk_q <= reg_wdata_in[2:0];
          `OCC_ADDR_HTH_A: hth_q <= reg_wdata_in;
          default: ;
        endcase
      end
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  pin3_route_a: assert property (pin_oen_n_out[0] == !(pcfg_q[0] && !pcfg_q[1]))
    else $error("pin3 enable wrong");
  pin4_route_a: assert property (pin_oen_n_out[1] == !(pcfg_q[4] && !pcfg_q[5]))
    else $error("pin4 enable wrong");
  pin_a_fault_a: assert property (a_low |=> pin_out[0] == pcfg_q[3])
    else $error("pin a not active");
  pin_b_fault_a: assert property (b_low |=> pin_out[1] == pcfg_q[7])
    else $error("pin b not active");
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data not idle");
  unmapped_read_a: assert property (reg_rd_in && reg_addr_in == 4'hf |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  hth_readback_a: assert property (reg_rd_in && reg_addr_in == `OCC_ADDR_HTH_A
    |=> reg_rdata_out == hth_q) else $error("high threshold readback");
  pincfg_readback_a: assert property (reg_rd_in && reg_addr_in == `OCC_ADDR_PINCFG
    |=> reg_rdata_out == {8'h00, pcfg_q}) else $error("pin config readback");
  irq_masked_a: assert property (imsk_q == 3'h0 |-> !irq_out)
    else $error("irq while masked");
  reset_pins_a: assert property ($rose(rstn_in) |-> pin_out == 2'b11 && pin_oen_n_out == 2'b11)
    else $error("pins not at reset level");
  cover property (a_low);
  cover property (irq_out);
  cover property (pin_oen_n_out == 2'b00);
endmodule
bind occ_comparator occ_assertions #(.OSR(OSR), .PWM_DIV(PWM_DIV)) occ_assertions_i (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .mod_bit_in(mod_bit_in),
  .mod_clk_en_in(mod_clk_en_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .pin_out(pin_out), .pin_oen_n_out(pin_oen_n_out), .irq_out(irq_out));

/* File: bench/occ_comparator_test.sv */
`timescale 1ns/1ps
`include "occ_defs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module occ_comparator_test;
  reg ref_clk_in = 1'b0;
  reg rstn_in = 1'b0;
  reg [3:0] reg_addr_in = 4'h0;
  reg [15:0] reg_wdata_in = 16'h0000;
  reg reg_wr_in = 1'b0;
  reg reg_rd_in = 1'b0;
  reg [7:0] level_a = 8'h80;
  reg [7:0] level_b = 8'h80;
  wire [1:0] mod_bit;
  wire mod_clk_en;
  wire [15:0] reg_rdata_out;
  wire [1:0] pin_out;
  wire [1:0] pin_oen_n_out;
  wire irq_out;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  occ_mod_model occ_mod_model_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .level_a_in(level_a), .level_b_in(level_b), .mod_bit_out(mod_bit), .mod_clk_en_out(mod_clk_en));
  occ_comparator occ_comparator_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .mod_bit_in(mod_bit), .mod_clk_en_in(mod_clk_en), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .pin_out(pin_out), .pin_oen_n_out(pin_oen_n_out),
    .irq_out(irq_out));
  initial begin
    forever #2.5 ref_clk_in = !ref_clk_in;
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input [3:0] a, input [15:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input [3:0] a, input [15:0] e, input string nm);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata_out)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic conclude;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // run is about 2660 cycles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      conclude();
    end
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    rd(`OCC_ADDR_HTH_A, 16'h7fff, "hth reset");
    rd(`OCC_ADDR_LTH_B, 16'h8000, "lth reset");
    rd(`OCC_ADDR_STATUS, 16'h000f, "status reset");
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000, "unmapped");
    level_a <= 8'hff;
    level_b <= 8'h00;
    wr(`OCC_ADDR_CTRL, 16'h000f);
    idle(600);
    rd(`OCC_ADDR_STATUS, 16'h000f, "thresholds off");
    wr(`OCC_ADDR_CTRL, 16'h0000);
    wr(`OCC_ADDR_HTH_A, 16'h4000);
    wr(`OCC_ADDR_LTH_B, 16'h4000);
    wr(`OCC_ADDR_CFG_B, 16'h0002);
    wr(`OCC_ADDR_PINCFG, 16'h0091);
    idle(2);
    `CHK("pin enables", 2'b00, pin_oen_n_out)
    `CHK("pins inactive", 2'b01, pin_out)
    wr(`OCC_ADDR_CTRL, 16'h000f);
    idle(400);
    rd(`OCC_ADDR_STATUS, 16'h000e, "high a");
    `CHK("pin a active", 2'b00, pin_out)
    rd(`OCC_ADDR_FAULT, 16'h0000, "combined");
    `CHK("irq masked", 1'b0, irq_out)
    wr(`OCC_ADDR_IRQ_MSK, 16'h0002);
    idle(1);
    `CHK("irq on", 1'b1, irq_out)
    wr(`OCC_ADDR_IRQ_ST, 16'h0002);
    idle(1);
    `CHK("irq cleared", 1'b0, irq_out)
    wr(`OCC_ADDR_FAULT, 16'h0001);
    rd(`OCC_ADDR_FAULT, 16'h0000, "early clear");
    wr(`OCC_ADDR_STATUS, 16'h0001);
    rd(`OCC_ADDR_STATUS, 16'h000e, "latched");
    wr(`OCC_ADDR_MASK, 16'h0008);
    idle(300);
    rd(`OCC_ADDR_STATUS, 16'h0006, "count two");
    `CHK("both pins", 2'b10, pin_out)
    wr(`OCC_ADDR_CTRL, 16'h0000);
    wr(`OCC_ADDR_STATUS, 16'h000f);
    rd(`OCC_ADDR_STATUS, 16'h000f, "flags cleared");
    idle(2);
    `CHK("pins released", 2'b01, pin_out)
    wr(`OCC_ADDR_FAULT, 16'h0001);
    rd(`OCC_ADDR_FAULT, 16'h0001, "late clear");
    wr(`OCC_ADDR_CTRL, 16'h000a);
    idle(576);
    wr(`OCC_ADDR_CTRL, 16'h0000);
    wr(`OCC_ADDR_CTRL, 16'h000a);
    idle(576);
    rd(`OCC_ADDR_STATUS, 16'h000f, "count restart");
    idle(128);
    rd(`OCC_ADDR_STATUS, 16'h0007, "masked flag");
    rd(`OCC_ADDR_FAULT, 16'h0001, "mask blocks");
    `CHK("pin ignores mask", 2'b11, pin_out)
    conclude();
  end
endmodule
